//--- hw/tsw_top.sv
/*
  Thermal sensor watchdog top: result, limit and configuration registers,
  periodic conversion, fault queue and alarm state, AHB-Lite register slave,
  two-wire serial register port and an event interrupt.
  Assumes adc_temp holds a settled 11-bit result whenever a conversion ends,
  and that the two-wire lines are sampled synchronously on clock.
*/
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
// How it works
// - Result kept as 11-bit signed, 0.125 degree steps
// - Normal mode converts, shutdown stops conversion
// - Alarm works as comparator or as interrupt
// - Alarm active level selectable high or low
// - Alarm needs programmed count of consecutive faults
// - Reset: normal, comparator, limits 80 and 75
// - Three pins give three slave address bits
// - Alarm pin open-drain, active past limits
// - Both limits writable and readable over serial
// - Mode, behaviour, polarity, queue in one register
// - Serial clock only received, data open-drain shared
// - One conversion each 100 ms, result updated
// - Upper address bits fixed at 1001
// - Comparator: set above high, clear below low
// - Interrupt: held till read, trips alternate
module tsw_top #(
  parameter int CONV_CYCLES = tsw_pkg::CONV_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_pin_bit2,
  input wire logic addr_pin_bit1,
  input wire logic addr_pin_bit0,
  input wire logic [10:0] adc_temp,
  output logic over_heat_alert_out,
  output logic over_heat_alert_oe_n,
  output logic irq
);

  localparam int LW = tsw_pkg::LIM_W;
  localparam int EW = tsw_pkg::EV_W;

  // Sensor registers
  logic [tsw_pkg::TEMP_W-1:0] temp_reg, temp_next;
  logic [7:0] conf_reg, conf_next;
  logic [LW-1:0] tos_reg, tos_next;
  logic [LW-1:0] thyst_reg, thyst_next;
  logic [6:0] slave_reg, slave_next;

  // Alarm state
  logic alarm_reg, alarm_next;
  logic phase_reg, phase_next;
  logic [2:0] fault_reg, fault_next;
  logic alert_oe_n_reg, alert_oe_n_next;

  // Events and interrupt
  logic [EW-1:0] status_reg, status_next;
  logic [EW-1:0] enable_reg, enable_next;
  logic irq_reg, irq_next;

  // Bus slave state
  logic dph_wr_reg, dph_wr_next;
  logic [2:0] dph_idx_reg, dph_idx_next;
  logic [31:0] hrdata_reg, hrdata_next;

  // Internal wires
  logic conv_done;
  logic [15:0] ser_word;
  tsw_pkg::tsw_ser_req_s ser_req;
  logic bus_take, bus_mapped, bus_read, any_read;
  logic [2:0] bus_idx;
  logic signed [LW-1:0] temp9;
  logic hot, cold, fault_now, trip;
  logic [2:0] queue_len;
  logic [EW-1:0] events, clear_bits;

  // Sensor register view as a 16-bit word, left aligned
  function automatic logic [15:0] sensor_word(input logic [1:0] ptr);
    logic [15:0] w;
    w = '0;
    unique case (ptr)
      tsw_pkg::PTR_TEMP: w = {temp_reg, 5'h00};
      tsw_pkg::PTR_CONF: w = {conf_reg, conf_reg};
      tsw_pkg::PTR_THYST: w = {thyst_reg, 7'h00};
      tsw_pkg::PTR_TOS: w = {tos_reg, 7'h00};
    endcase
    return w;
  endfunction

  // Conversion period only runs outside shutdown
  tsw_conv_timer #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .run(!conf_reg[tsw_pkg::CONF_SHUTDOWN]),
    .done(conv_done)
  );

  // Serial register port; slave only, clock is an input
  tsw_ser_slave u_ser (
    .clock(clock),
    .rst(rst),
    .slave_addr(slave_reg),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .rd_word(ser_word),
    .req(ser_req)
  );

  assign ser_word = sensor_word(ser_req.ptr);

  // AHB address phase decode; every slot below 0x20 is mapped
  assign bus_take = hsel && hready && htrans[tsw_pkg::HTRANS_ACTIVE];
  assign bus_idx = haddr[tsw_pkg::ADDR_IDX_HI:tsw_pkg::ADDR_IDX_LO];
  assign bus_mapped = (haddr[31:tsw_pkg::ADDR_IDX_HI+1] == '0);
  assign bus_read = bus_take && !hwrite && bus_mapped && (bus_idx <= {1'b0, tsw_pkg::PTR_TOS});
  // Any sensor register read from either port releases an interrupt alarm
  assign any_read = bus_read || ser_req.rd;

  // Limits use the nine top result bits
  assign temp9 = adc_temp[tsw_pkg::TEMP_W-1:tsw_pkg::TEMP_W-LW];
  assign hot = temp9 > $signed(tos_reg);
  assign cold = temp9 < $signed(thyst_reg);
  assign queue_len = tsw_pkg::tsw_queue_len(conf_reg[tsw_pkg::CONF_QUEUE_HI:tsw_pkg::CONF_QUEUE_LO]);

  // Which side must be crossed next depends on the behaviour
  always_comb begin
    if (conf_reg[tsw_pkg::CONF_INT_MODE]) begin
      fault_now = phase_reg ? cold : hot;
    end else begin
      fault_now = alarm_reg ? cold : hot;
    end
  end

  assign trip = conv_done && fault_now && ((fault_reg + 3'h1) >= queue_len);

  // Result, fault queue and alarm state, advanced once per conversion
  always_comb begin
    temp_next = temp_reg;
    fault_next = fault_reg;
    alarm_next = alarm_reg;
    phase_next = phase_reg;
    if (conf_reg[tsw_pkg::CONF_INT_MODE] && any_read) begin
      alarm_next = 1'b0;
    end
    if (conv_done) begin
      temp_next = adc_temp;
      if (!fault_now) begin
        fault_next = '0;
      end else if (!trip) begin
        fault_next = fault_reg + 3'h1;
      end else begin
        fault_next = '0;
        // A trip wins over a read in the same cycle
        if (conf_reg[tsw_pkg::CONF_INT_MODE]) begin
          alarm_next = 1'b1;
          phase_next = !phase_reg;
        end else begin
          alarm_next = !alarm_reg;
        end
      end
    end
    // Open-drain pin: released reads as high through the pull-up
    if (alarm_next) begin
      alert_oe_n_next = conf_reg[tsw_pkg::CONF_POL_HIGH];
    end else begin
      alert_oe_n_next = !conf_reg[tsw_pkg::CONF_POL_HIGH];
    end
  end

  // Register writes; the system bus wins a same-cycle clash
  always_comb begin
    conf_next = conf_reg;
    tos_next = tos_reg;
    thyst_next = thyst_reg;
    enable_next = enable_reg;
    clear_bits = '0;
    slave_next = {tsw_pkg::SLAVE_HI, addr_pin_bit2, addr_pin_bit1, addr_pin_bit0};
    if (dph_wr_reg) begin
      unique case (dph_idx_reg)
        {1'b0, tsw_pkg::PTR_CONF}: conf_next = hwdata[7:0];
        {1'b0, tsw_pkg::PTR_THYST}: thyst_next = hwdata[15:16-LW];
        {1'b0, tsw_pkg::PTR_TOS}: tos_next = hwdata[15:16-LW];
        tsw_pkg::IDX_ENABLE: enable_next = hwdata[EW-1:0];
        tsw_pkg::IDX_CLEAR: clear_bits = hwdata[EW-1:0];
        default: ;
      endcase
    end else if (ser_req.wr) begin
      unique case (ser_req.ptr)
        tsw_pkg::PTR_CONF: conf_next = ser_req.wdata[15:8];
        tsw_pkg::PTR_THYST: thyst_next = ser_req.wdata[15:16-LW];
        tsw_pkg::PTR_TOS: tos_next = ser_req.wdata[15:16-LW];
        default: ; // Result is read only
      endcase
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_comb begin
    events = '0;
    events[tsw_pkg::EV_CONV] = conv_done;
    events[tsw_pkg::EV_TRIP] = trip;
    events[tsw_pkg::EV_SER_WR] = ser_req.wr;
    status_next = (status_reg & ~clear_bits) | events;
    irq_next = |(status_next & enable_reg);
  end

  // AHB slave: zero wait states, read data prepared in the address phase
  always_comb begin
    dph_wr_next = bus_take && hwrite && bus_mapped;
    dph_idx_next = bus_idx;
    hrdata_next = hrdata_reg;
    if (bus_take && !hwrite) begin
      hrdata_next = '0;
      if (bus_mapped) begin
        unique case (bus_idx)
          {1'b0, tsw_pkg::PTR_TEMP}: hrdata_next = {16'h0000, sensor_word(tsw_pkg::PTR_TEMP)};
          {1'b0, tsw_pkg::PTR_CONF}: hrdata_next = {24'h000000, conf_reg};
          {1'b0, tsw_pkg::PTR_THYST}: hrdata_next = {16'h0000, sensor_word(tsw_pkg::PTR_THYST)};
          {1'b0, tsw_pkg::PTR_TOS}: hrdata_next = {16'h0000, sensor_word(tsw_pkg::PTR_TOS)};
          tsw_pkg::IDX_STATUS: hrdata_next = {{(32-EW){1'b0}}, status_reg};
          tsw_pkg::IDX_ENABLE: hrdata_next = {{(32-EW){1'b0}}, enable_reg};
          tsw_pkg::IDX_SLAVE: hrdata_next = {25'h0000000, slave_reg};
          default: hrdata_next = '0; // Clear register reads as zero
        endcase
      end
    end
  end

  // Registers; reset values give a stand-alone thermostat
  always_ff @(posedge clock) begin
    if (rst) begin
      temp_reg <= '0;
      conf_reg <= tsw_pkg::CONF_RST;
      tos_reg <= tsw_pkg::TOS_RST[15:16-LW];
      thyst_reg <= tsw_pkg::THYST_RST[15:16-LW];
      slave_reg <= '0;
      alarm_reg <= 1'b0;
      phase_reg <= 1'b0;
      fault_reg <= '0;
      alert_oe_n_reg <= 1'b1;
      status_reg <= '0;
      enable_reg <= '0;
      irq_reg <= 1'b0;
      dph_wr_reg <= 1'b0;
      dph_idx_reg <= '0;
      hrdata_reg <= '0;
    end else begin
      temp_reg <= temp_next;
      conf_reg <= conf_next;
      tos_reg <= tos_next;
      thyst_reg <= thyst_next;
      slave_reg <= slave_next;
      alarm_reg <= alarm_next;
      phase_reg <= phase_next;
      fault_reg <= fault_next;
      alert_oe_n_reg <= alert_oe_n_next;
      status_reg <= status_next;
      enable_reg <= enable_next;
      irq_reg <= irq_next;
      dph_wr_reg <= dph_wr_next;
      dph_idx_reg <= dph_idx_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Outputs; the alert pin only ever pulls low
  assign over_heat_alert_out = 1'b0;
  assign over_heat_alert_oe_n = alert_oe_n_reg;
  assign irq = irq_reg;
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule // tsw_top

//--- hw/tsw_pkg.sv
/*
  Shared constants and types for the thermal sensor watchdog: register
  indices, bus byte addresses, reset values, configuration fields, status
  bits, conversion timing and the serial request carrier.
  Assumes a single 10 MHz clock and a synchronous active-high reset.
*/
package tsw_pkg;

  // Clock and conversion timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CONV_TIME_MS = 100;
  localparam int CONV_CYCLES = (CLK_HZ / 1000) * CONV_TIME_MS;
  localparam int CONV_CNT_W = 24;

  // Data widths
  localparam int TEMP_W = 11;
  localparam int LIM_W = 9;
  localparam int WORD_W = 16;

  // Register indices, as printed pointer values
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CONF = 2'h1;
  localparam logic [1:0] PTR_THYST = 2'h2;
  localparam logic [1:0] PTR_TOS = 2'h3;

  // Word indices of the extra registers on the system bus
  localparam logic [2:0] IDX_STATUS = 3'h4;
  localparam logic [2:0] IDX_ENABLE = 3'h5;
  localparam logic [2:0] IDX_CLEAR = 3'h6;
  localparam logic [2:0] IDX_SLAVE = 3'h7;

  // Byte addresses: four times the index
  localparam logic [31:0] ADDR_TEMP = 32'h0000_0000;
  localparam logic [31:0] ADDR_CONF = 32'h0000_0004;
  localparam logic [31:0] ADDR_THYST = 32'h0000_0008;
  localparam logic [31:0] ADDR_TOS = 32'h0000_000c;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
  localparam logic [31:0] ADDR_ENABLE = 32'h0000_0014;
  localparam logic [31:0] ADDR_CLEAR = 32'h0000_0018;
  localparam logic [31:0] ADDR_SLAVE = 32'h0000_001c;
  localparam int ADDR_IDX_LO = 2;
  localparam int ADDR_IDX_HI = 4;

  // Reset values
  localparam logic [7:0] CONF_RST = 8'h00;
  localparam logic [15:0] TOS_RST = 16'h5000;
  localparam logic [15:0] THYST_RST = 16'h4b00;

  // Configuration fields
  localparam int CONF_SHUTDOWN = 0;
  localparam int CONF_INT_MODE = 1;
  localparam int CONF_POL_HIGH = 2;
  localparam int CONF_QUEUE_LO = 3;
  localparam int CONF_QUEUE_HI = 4;

  // Status, enable and clear bit positions
  localparam int EV_W = 3;
  localparam int EV_CONV = 0;
  localparam int EV_TRIP = 1;
  localparam int EV_SER_WR = 2;

  // Fixed upper part of the serial slave address
  localparam logic [3:0] SLAVE_HI = 4'h9;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int HTRANS_ACTIVE = 1;

  // Register request from the serial port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] ptr;
    logic [WORD_W-1:0] wdata;
  } tsw_ser_req_s;

  // Fault queue code to number of consecutive faults
  function automatic logic [2:0] tsw_queue_len(input logic [1:0] code);
    logic [2:0] len;
    len = 3'h1;
    unique case (code)
      2'h0: len = 3'h1;
      2'h1: len = 3'h2;
      2'h2: len = 3'h4;
      2'h3: len = 3'h6;
    endcase
    return len;
  endfunction

endpackage

//--- hw/tsw_conv_timer.sv
/*
  Conversion period timer: emits a one-cycle done strobe every period while
  run is high. Restarts from zero whenever run goes low, so a new conversion
  starts on leaving shutdown. Assumes the parent holds run steady per mode.
*/
module tsw_conv_timer #(
  parameter int CONV_CYCLES = tsw_pkg::CONV_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  output logic done
);

  logic [tsw_pkg::CONV_CNT_W-1:0] cnt_reg;
  logic [tsw_pkg::CONV_CNT_W-1:0] cnt_next;
  logic done_reg;
  logic done_next;
  localparam logic [tsw_pkg::CONV_CNT_W-1:0] LAST = tsw_pkg::CONV_CNT_W'(CONV_CYCLES - 1);

  // Count the period, wrap and flag the end
  always_comb begin
    cnt_next = cnt_reg + 1'b1;
    done_next = 1'b0;
    if (!run) begin
      cnt_next = '0;
    end else if (cnt_reg == LAST) begin
      cnt_next = '0;
      done_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;

endmodule // tsw_conv_timer

//--- hw/tsw_ser_slave.sv
/*
  Two-wire serial slave: address match, pointer byte, register write of one
  or two bytes, register read of a repeating 16-bit word. Clock and data
  lines are sampled on the system clock, which must be far faster than the
  serial clock. Data pin is open-drain: oe_n low pulls the line low.
*/
module tsw_ser_slave (
  input wire logic clock,
  input wire logic rst,
  input wire logic [6:0] slave_addr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [15:0] rd_word,
  output tsw_pkg::tsw_ser_req_s req
);

  typedef enum {S_IDLE, S_RECV, S_ACK_WAIT, S_ACK, S_SEND, S_RACK} tsw_ser_state_e;

  tsw_ser_state_e state_reg, state_next;
  logic scl_reg, sda_reg;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bit_reg, bit_next;
  logic [1:0] byte_reg, byte_next;
  logic read_reg, read_next;
  logic [1:0] ptr_reg, ptr_next;
  logic [7:0] msb_reg, msb_next;
  logic [15:0] tx_reg, tx_next;
  logic oe_n_reg, oe_n_next;
  tsw_pkg::tsw_ser_req_s req_reg, req_next;
  logic rise, fall, start, stop;
  logic [7:0] full;

  // Line events; the inputs are already synchronous
  assign rise = scl_in && !scl_reg;
  assign fall = !scl_in && scl_reg;
  assign start = scl_in && scl_reg && sda_reg && !sda_in;
  assign stop = scl_in && scl_reg && !sda_reg && sda_in;
  assign full = {shift_reg[6:0], sda_in};

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    byte_next = byte_reg;
    read_next = read_reg;
    ptr_next = ptr_reg;
    msb_next = msb_reg;
    tx_next = tx_reg;
    oe_n_next = oe_n_reg;
    req_next = '0;
    req_next.ptr = ptr_reg;
    if (start) begin
      state_next = S_RECV;
      bit_next = '0;
      byte_next = '0;
      oe_n_next = 1'b1;
    end else if (stop) begin
      state_next = S_IDLE;
      oe_n_next = 1'b1;
    end else begin
      unique case (state_reg)
        S_IDLE: ;
        S_RECV: if (rise) begin
          shift_next = full;
          bit_next = bit_reg + 1'b1;
          if (bit_reg == 3'h7) begin
            state_next = S_ACK_WAIT;
            if (byte_reg == 2'h0) begin
              // Upper four bits fixed, lower three from the pins
              if (full[7:1] != slave_addr) state_next = S_IDLE;
              read_next = full[0];
              if (full[0] && full[7:1] == slave_addr) begin
                req_next.rd = 1'b1;
                tx_next = rd_word;
              end
            end else if (byte_reg == 2'h1) begin
              ptr_next = full[1:0];
            end else if (byte_reg == 2'h2) begin
              msb_next = full;
              if (ptr_reg == tsw_pkg::PTR_CONF) begin
                req_next.wr = 1'b1;
                req_next.wdata = {full, 8'h00};
              end
            end else if (ptr_reg != tsw_pkg::PTR_CONF) begin
              req_next.wr = 1'b1;
              req_next.wdata = {msb_reg, full};
            end
            if (byte_reg != 2'h3) byte_next = byte_reg + 1'b1;
          end
        end
        S_ACK_WAIT: if (fall) begin
          oe_n_next = 1'b0;
          state_next = S_ACK;
        end
        S_ACK: if (fall) begin
          // Data line is only pulled low, never driven high
          oe_n_next = read_reg ? tx_reg[15] : 1'b1;
          state_next = read_reg ? S_SEND : S_RECV;
        end
        S_SEND: begin
          if (fall) oe_n_next = tx_reg[15];
          if (rise) begin
            tx_next = {tx_reg[14:0], tx_reg[15]};
            bit_next = bit_reg + 1'b1;
            if (bit_reg == 3'h7) state_next = S_RACK;
          end
        end
        S_RACK: begin
          if (fall) oe_n_next = 1'b1;
          if (rise) state_next = sda_in ? S_IDLE : S_SEND;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= S_IDLE;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      shift_reg <= '0;
      bit_reg <= '0;
      byte_reg <= '0;
      read_reg <= 1'b0;
      ptr_reg <= tsw_pkg::PTR_TEMP;
      msb_reg <= '0;
      tx_reg <= '0;
      oe_n_reg <= 1'b1;
      req_reg <= '0;
    end else begin
      state_reg <= state_next;
      scl_reg <= scl_in;
      sda_reg <= sda_in;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      read_reg <= read_next;
      ptr_reg <= ptr_next;
      msb_reg <= msb_next;
      tx_reg <= tx_next;
      oe_n_reg <= oe_n_next;
      req_reg <= req_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_reg;
  assign req = req_reg;

endmodule // tsw_ser_slave

//--- testbench/tsw_top_asserts.sv
/*
  Checker for tsw_top: bus answer, pin, read data and interrupt relations.
  Sees only the top ports; bound from the bench top file.
*/
module tsw_top_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic addr_pin_bit2,
  input wire logic addr_pin_bit1,
  input wire logic addr_pin_bit0,
  input wire logic over_heat_alert_out,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Transfers taken in an address phase
  wire logic rd_take = hsel && hready && htrans[1] && !hwrite;
  wire logic wr_take = hsel && hready && htrans[1] && hwrite;
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus wait or error answer");
  property p_od; !sda_out && !over_heat_alert_out; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_slave;
    rd_take && haddr == tsw_pkg::ADDR_SLAVE |=>
      hrdata == {25'h0, tsw_pkg::SLAVE_HI, addr_pin_bit2, addr_pin_bit1, addr_pin_bit0};
  endproperty
  a_slave: assert property (p_slave) else $error("slave address wrong");
  property p_temp_lsb;
    rd_take && haddr == tsw_pkg::ADDR_TEMP |=> hrdata[4:0] == 5'h0 && hrdata[31:16] == 16'h0;
  endproperty
  a_temp_lsb: assert property (p_temp_lsb) else $error("result unused bits set");
  property p_limit;
    rd_take && haddr[31:5] == 27'h0 && haddr[4:3] == 2'h1 |=>
      hrdata[6:0] == 7'h0 && hrdata[31:16] == 16'h0;
  endproperty
  a_limit: assert property (p_limit) else $error("limit unused bits set");
  property p_irq_off;
    wr_take && haddr == tsw_pkg::ADDR_ENABLE ##1 hwdata[2:0] == 3'h0 |-> ##3 !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt still high");
  property p_sda_hold; scl_in && $past(scl_in) |-> $stable(sda_oe_n); endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("data moved in clock high");
  property p_rdata_hold; !rd_take |=> $stable(hrdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  // Main scenarios reached
  c_irq: cover property ($rose(irq));
  c_ack: cover property ($fell(sda_oe_n));
  c_slave: cover property (rd_take && haddr == tsw_pkg::ADDR_SLAVE);
endmodule // tsw_top_asserts

//--- testbench/tsw_i2c_model.sv
/*
  Two-wire bus controller model: makes the serial clock, writes bytes.
  Assumes a pull-up on the data line, so released data reads as 1.
*/
module tsw_i2c_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: clock parked high between frames, data released
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  // One third of the serial clock period in a byte, well above the slave's minimum
  task automatic hc();
    repeat (6) @(posedge clock);
  endtask
  // Start: data falls while the clock is high
  task automatic start();
    sda_o <= 1'b0;
    hc();
    scl <= 1'b0; // Controller alone supplies the clock
    hc();
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    sda_o <= 1'b0;
    hc();
    scl <= 1'b1;
    hc();
    sda_o <= 1'b1;
    hc();
  endtask
  // Byte MSB first, then the acknowledge slot with data released
  task automatic tx(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_o <= (i == 0) ? 1'b1 : b[i-1]; // Register writes over the bus
      hc();
      scl <= 1'b1;
      hc();
      ack = sda;
      scl <= 1'b0;
      hc();
    end
  endtask
endmodule // tsw_i2c_model

//--- testbench/test_thermal_sensor_watchdog.sv
/*
  Bench top for tsw_top: AHB-Lite master tasks, serial controller model,
  pulled-up open-drain lines and the checker bind. Short conversion period.
*/
module test_thermal_sensor_watchdog;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV = 50;
  localparam int LENS [4] = '{1, 2, 4, 6};
  localparam logic [10:0] HOT = 11'h284, AT_TOS = 11'h280, MID = 11'h270, COLD = 11'h250;
  logic clock, rst, hsel, hwrite, hreadyout, hresp, sda_oe_n, sda_out;
  logic m_scl, m_sda, ack, alert_oe_n, alert_out, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [10:0] adc_temp;
  logic [2:0] pins;
  int fail_count = 0, compares = 0, cyc = 0;
  // Pull-ups: released lines read high
  wire logic sda_line = m_sda & (sda_oe_n | sda_out);
  wire logic alert = alert_oe_n | alert_out;
  tsw_top #(.CONV_CYCLES(CONV)) i_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scl_in(m_scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_pin_bit2(pins[2]), .addr_pin_bit1(pins[1]),
    .addr_pin_bit0(pins[0]), .adc_temp(adc_temp), .over_heat_alert_out(alert_out),
    .over_heat_alert_oe_n(alert_oe_n), .irq(irq));
  tsw_i2c_model i_m (.clock(clock), .sda(sda_line), .scl(m_scl), .sda_o(m_sda));
  // Clock, and a ceiling on run length
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 12000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // One single transfer; waits on ready, never on a cycle count
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic al(input logic e);
    repeat (2) @(posedge clock);
    chk("alert", 32'(e), 32'(alert));
  endtask
  // Present a result and wait for the next conversion to end
  task automatic conv(input logic [10:0] t);
    int n;
    n = 0;
    adc_temp <= t;
    xfer(1'b1, tsw_pkg::ADDR_CLEAR, 32'h7);
    repeat (2) @(posedge clock);
    while (irq !== 1'b1 && n < CONV + 10) begin
      @(posedge clock);
      n++;
    end
    chk("conv", 32'h1, 32'(irq));
  endtask
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pins = 3'h5;
    adc_temp = 11'h0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rc("conf", tsw_pkg::ADDR_CONF, 32'h0);
    rc("thyst", tsw_pkg::ADDR_THYST, 32'h4b00);
    rc("tos", tsw_pkg::ADDR_TOS, 32'h5000);
    rc("slave", tsw_pkg::ADDR_SLAVE, 32'h4d);
    rc("unmapped", 32'h20, 32'h0);
    al(1'b1);
    // Comparator: equal is no fault, then set and hysteresis
    xfer(1'b1, tsw_pkg::ADDR_ENABLE, 32'h1);
    conv(AT_TOS);
    al(1'b1);
    conv(HOT);
    rc("temp", tsw_pkg::ADDR_TEMP, {16'h0, HOT, 5'h0});
    rc("status", tsw_pkg::ADDR_STATUS, 32'h3);
    al(1'b0);
    conv(MID);
    al(1'b0);
    conv(COLD);
    al(1'b1);
    // Every queue depth, active high
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, tsw_pkg::ADDR_CONF, {27'h0, c[1:0], 3'h4});
      for (int k = 1; k <= LENS[c]; k++) begin
        conv(HOT);
        al(k == LENS[c]);
      end
      for (int k = 1; k <= LENS[c]; k++) conv(COLD);
      al(1'b0);
    end
    // A result without fault restarts the count
    xfer(1'b1, tsw_pkg::ADDR_CONF, 32'hc);
    conv(HOT);
    conv(MID);
    conv(HOT);
    al(1'b0);
    conv(HOT);
    al(1'b1);
    conv(COLD);
    conv(COLD);
    // Interrupt behaviour: held until a read, trips alternate
    xfer(1'b1, tsw_pkg::ADDR_CONF, 32'h2);
    conv(HOT);
    al(1'b0);
    conv(MID);
    al(1'b0);
    rc("temp", tsw_pkg::ADDR_TEMP, {16'h0, MID, 5'h0});
    al(1'b1);
    conv(HOT);
    al(1'b1);
    conv(COLD);
    al(1'b0);
    rc("conf", tsw_pkg::ADDR_CONF, 32'h2);
    al(1'b1);
    // Shutdown holds the result and stops conversions
    xfer(1'b1, tsw_pkg::ADDR_CONF, 32'h1);
    adc_temp <= MID;
    xfer(1'b1, tsw_pkg::ADDR_CLEAR, 32'h7);
    repeat (3 * CONV) @(posedge clock);
    rc("status", tsw_pkg::ADDR_STATUS, 32'h0);
    rc("temp", tsw_pkg::ADDR_TEMP, {16'h0, COLD, 5'h0});
    xfer(1'b1, tsw_pkg::ADDR_CONF, 32'h0);
    conv(MID);
    rc("temp", tsw_pkg::ADDR_TEMP, {16'h0, MID, 5'h0});
    xfer(1'b1, tsw_pkg::ADDR_ENABLE, 32'h0);
    repeat (CONV + 10) @(posedge clock);
    chk("irq", 32'h0, 32'(irq));
    // Serial write of the high limit, then a foreign address
    i_m.start();
    i_m.tx({tsw_pkg::SLAVE_HI, pins, 1'b0}, ack);
    chk("ack", 32'h0, 32'(ack));
    i_m.tx(8'h03, ack);
    i_m.tx(8'h64, ack);
    i_m.tx(8'h00, ack);
    chk("ack", 32'h0, 32'(ack));
    i_m.stop();
    rc("tos", tsw_pkg::ADDR_TOS, 32'h6400);
    i_m.start();
    i_m.tx({tsw_pkg::SLAVE_HI, 3'h4, 1'b0}, ack);
    chk("nack", 32'h1, 32'(ack));
    i_m.stop();
    close_out();
  end
endmodule // test_thermal_sensor_watchdog
bind tsw_top tsw_top_asserts i_chk (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .addr_pin_bit2(addr_pin_bit2), .addr_pin_bit1(addr_pin_bit1), .addr_pin_bit0(addr_pin_bit0),
  .over_heat_alert_out(over_heat_alert_out), .irq(irq));
